// file: logic/hibir_requester.sv
`timescale 1ns/10ps
`include "hibir_consts.svh"

module hibir_requester (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire logic i3cMode,
    input wire logic pecEnable,
    input wire logic [2:0] hubSelectCode,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgData,
    // event status from the sensor logic
    input wire logic [7:0] tempEventStatus,
    input wire logic [7:0] errorEventStatus,
    // host bus pins
    input wire logic hostClockLine,
    input wire logic hostDataIn,
    output logic hostDataOut,
    output logic hostDataOe,
    // status
    output logic [7:0] interruptConfig,
    output logic ibiStatusFlag,
    output logic [3:0] pendingBits,
    output logic ibiBusy
);

    hibir_pkg::hibir_state_t state_reg;
    logic [7:0] cfg_reg;
    logic sclMeta_reg, sclSync_reg, sclPrev_reg;
    logic sdaMeta_reg, sdaSync_reg, sdaPrev_reg;
    logic [7:0] tempPrev_reg, errPrev_reg;
    logic flag_reg, reqPend_reg;
    logic [3:0] pend_reg;
    logic [11:0] idleCnt_reg;
    logic [3:0] bitCnt_reg;
    logic [1:0] byteIdx_reg;
    logic [7:0] shift_reg, tempCap_reg, errCap_reg;
    logic drvBit_reg, pushPull_reg, ack_reg;

    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `HIBIR_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [7:0] byteAt(input logic [1:0] idx, input logic [7:0] t,
                                          input logic [7:0] e, input logic [7:0] p);
        logic [7:0] b;
        b = `HIBIR_MDB;
        if (idx == 2'h1) begin
            b = t;
        end else if (idx == 2'h2) begin
            b = e;
        end else if (idx == 2'h3) begin
            b = p;
        end
        return b;
    endfunction

    // bus edges, seen only through the second sync stage
    wire sclRise = sclSync_reg & ~sclPrev_reg;
    wire sclFall = ~sclSync_reg & sclPrev_reg;
    wire sdaRise = sdaSync_reg & ~sdaPrev_reg;
    wire sdaFall = ~sdaSync_reg & sdaPrev_reg;
    wire busStart = sdaFall & sclSync_reg & sclPrev_reg;
    wire busStop = sdaRise & sclSync_reg & sclPrev_reg;
    wire anyEdge = sclRise | sclFall | sdaRise | sdaFall;

    wire globalEn = cfg_reg[`HIBIR_GLOBAL_EN_BIT];
    wire [7:0] errRise = errorEventStatus & ~errPrev_reg & `HIBIR_ERR_MASK;
    wire [7:0] tempRise = tempEventStatus & ~tempPrev_reg & `HIBIR_TEMP_MASK;
    wire [3:0] tempHit = tempRise[3:0] & cfg_reg[`HIBIR_TEMP_EN_MSB:0];
    wire flagEvt = (|errRise) | (|tempHit);
    wire reqEvt = globalEn & flagEvt;

    wire [7:0] addrByte = {`HIBIR_LOCAL_TYPE, hubSelectCode, 1'b1};
    wire [7:0] pecByte = crc8(crc8(crc8(crc8(`HIBIR_CRC_INIT, addrByte), `HIBIR_MDB), tempCap_reg), errCap_reg);
    wire [1:0] lastIdx = pecEnable ? 2'h3 : 2'h2;
    wire [1:0] nextIdx = byteIdx_reg + 2'h1;
    wire [7:0] nextByte = byteAt(nextIdx, tempCap_reg, errCap_reg, pecByte);

    wire isIdle = state_reg == hibir_pkg::ST_IDLE;
    wire idleDone = idleCnt_reg == 12'(`HIBIR_AVAL_CYC);
    wire canReq = isIdle & reqPend_reg & i3cMode;
    wire goSelf = canReq & idleDone & ~busStart;
    wire goHost = canReq & busStart;
    wire lostArb = (state_reg == hibir_pkg::ST_ADDR) & sclRise & drvBit_reg & ~sdaSync_reg;
    wire abortT = (state_reg == hibir_pkg::ST_DATA) & sclRise & (bitCnt_reg == 4'h9)
                  & drvBit_reg & ~sdaSync_reg;
    wire doneEvt = (state_reg == hibir_pkg::ST_DATA) & sclFall & (bitCnt_reg == 4'h9)
                   & ~drvBit_reg;

    assign hostDataOut = pushPull_reg & drvBit_reg;
    assign hostDataOe = ~isIdle & (pushPull_reg | ~drvBit_reg);
    assign interruptConfig = cfg_reg;
    assign ibiStatusFlag = flag_reg;
    assign pendingBits = pend_reg;
    assign ibiBusy = ~isIdle;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {sclMeta_reg, sclSync_reg, sclPrev_reg} <= 3'h7;
            {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= 3'h7;
        end else begin
            {sclMeta_reg, sclSync_reg, sclPrev_reg} <= {hostClockLine, sclMeta_reg, sclSync_reg};
            {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= {hostDataIn, sdaMeta_reg, sdaSync_reg};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= `HIBIR_CFG_RESET;
            tempPrev_reg <= 8'h00;
            errPrev_reg <= 8'h00;
        end else begin
            if (cfgWrite) begin
                cfg_reg <= cfgData;
            end
            tempPrev_reg <= tempEventStatus;
            errPrev_reg <= errorEventStatus;
        end
    end

    // a new event in the completion cycle wins over the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
            pend_reg <= `HIBIR_PEND_CLR;
            reqPend_reg <= 1'b0;
        end else if (flagEvt) begin
            flag_reg <= 1'b1;
            pend_reg <= `HIBIR_PEND_SET;
            reqPend_reg <= reqPend_reg | reqEvt;
        end else if (doneEvt) begin
            flag_reg <= 1'b0;
            pend_reg <= `HIBIR_PEND_CLR;
            reqPend_reg <= 1'b0;
        end
    end

    // quiet-bus timer, restarted by any edge or while busy
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idleCnt_reg <= 12'h000;
        end else if (anyEdge | ~isIdle) begin
            idleCnt_reg <= 12'h000;
        end else if (!idleDone) begin
            idleCnt_reg <= idleCnt_reg + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= hibir_pkg::ST_IDLE;
            bitCnt_reg <= 4'h0;
            byteIdx_reg <= 2'h0;
            shift_reg <= 8'h00;
            drvBit_reg <= 1'b1;
            pushPull_reg <= 1'b0;
            ack_reg <= 1'b0;
            tempCap_reg <= 8'h00;
            errCap_reg <= 8'h00;
        end else if (!isIdle && busStop) begin
            // a stop ends any transfer; flags are cleared only on completion
            state_reg <= hibir_pkg::ST_IDLE;
            drvBit_reg <= 1'b1;
            pushPull_reg <= 1'b0;
        end else begin
            case (state_reg)
                hibir_pkg::ST_IDLE: begin
                    if (goSelf || goHost) begin
                        state_reg <= hibir_pkg::ST_ARM;
                        drvBit_reg <= ~goSelf;
                        pushPull_reg <= 1'b0;
                    end
                end
                hibir_pkg::ST_ARM: begin
                    if (sclFall) begin
                        drvBit_reg <= addrByte[7];
                        shift_reg <= {addrByte[6:0], 1'b0};
                        bitCnt_reg <= 4'h1;
                        state_reg <= hibir_pkg::ST_ADDR;
                    end
                end
                hibir_pkg::ST_ADDR: begin
                    if (lostArb) begin
                        drvBit_reg <= 1'b1;
                        state_reg <= hibir_pkg::ST_WAIT;
                    end else if (sclFall && bitCnt_reg == 4'h8) begin
                        drvBit_reg <= 1'b1;
                        state_reg <= hibir_pkg::ST_ACK;
                    end else if (sclFall) begin
                        drvBit_reg <= shift_reg[7];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                end
                hibir_pkg::ST_ACK: begin
                    if (sclRise) begin
                        ack_reg <= ~sdaSync_reg;
                        tempCap_reg <= tempEventStatus;
                        errCap_reg <= errorEventStatus;
                    end else if (sclFall && ack_reg) begin
                        drvBit_reg <= 1'(`HIBIR_MDB >> 7);
                        shift_reg <= `HIBIR_MDB;
                        pushPull_reg <= 1'b1;
                        bitCnt_reg <= 4'h1;
                        byteIdx_reg <= 2'h0;
                        state_reg <= hibir_pkg::ST_DATA;
                    end else if (sclFall) begin
                        state_reg <= hibir_pkg::ST_WAIT;
                    end
                end
                hibir_pkg::ST_DATA: begin
                    if (abortT) begin
                        pushPull_reg <= 1'b0;
                        state_reg <= hibir_pkg::ST_WAIT;
                    end else if (sclFall && bitCnt_reg < 4'h8) begin
                        drvBit_reg <= shift_reg[6];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == 4'h8) begin
                        // T=1 is released so the host may pull it low to abort
                        drvBit_reg <= byteIdx_reg != lastIdx;
                        pushPull_reg <= byteIdx_reg == lastIdx;
                        bitCnt_reg <= 4'h9;
                    end else if (sclFall && drvBit_reg) begin
                        drvBit_reg <= nextByte[7];
                        shift_reg <= nextByte;
                        pushPull_reg <= 1'b1;
                        byteIdx_reg <= nextIdx;
                        bitCnt_reg <= 4'h1;
                    end else if (sclFall) begin
                        drvBit_reg <= 1'b1;
                        pushPull_reg <= 1'b0;
                        state_reg <= hibir_pkg::ST_WAIT;
                    end
                end
                default: begin
                    drvBit_reg <= 1'b1;
                    pushPull_reg <= 1'b0;
                end
            endcase
        end
    end

    a_legacy_no_ibi: assert property (@(posedge ref_clk) disable iff (rst)
        (isIdle && !i3cMode) |=> isIdle)
        else $error("request started outside I3C mode");

    a_reset_disabled: assert property (@(posedge ref_clk) disable iff (rst)
        (!globalEn && !reqPend_reg) |=> !reqPend_reg)
        else $error("request armed while globally disabled");

    a_err_arms_req: assert property (@(posedge ref_clk) disable iff (rst)
        (globalEn && |errRise) |=> reqPend_reg && flag_reg && pend_reg == `HIBIR_PEND_SET)
        else $error("enabled error did not arm a request");

    a_err_flag_only: assert property (@(posedge ref_clk) disable iff (rst)
        (!globalEn && |errRise) |=> flag_reg && pend_reg == `HIBIR_PEND_SET && $stable(reqPend_reg))
        else $error("disabled error handled wrongly");

    a_temp_flag: assert property (@(posedge ref_clk) disable iff (rst)
        (|tempHit) |=> flag_reg && pend_reg == `HIBIR_PEND_SET && (reqPend_reg || !$past(globalEn)))
        else $error("temperature event not recorded");

    a_self_start: assert property (@(posedge ref_clk) disable iff (rst)
        (goSelf && !busStop) |=> state_reg == hibir_pkg::ST_ARM && hostDataOe && !hostDataOut)
        else $error("quiet-bus request did not pull data low");

    a_addr_first_bit: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == hibir_pkg::ST_ARM && sclFall && !busStop) |=> state_reg == hibir_pkg::ST_ADDR
        && drvBit_reg == addrByte[7] && bitCnt_reg == 4'h1)
        else $error("address bit 7 not driven on first fall");

    a_done_clears: assert property (@(posedge ref_clk) disable iff (rst)
        (doneEvt && !flagEvt) |=> !flag_reg && pend_reg == `HIBIR_PEND_CLR && !reqPend_reg)
        else $error("completion did not clear status");

    a_nack_keeps: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == hibir_pkg::ST_ACK && sclFall && !ack_reg && !busStop)
        |=> state_reg == hibir_pkg::ST_WAIT && $stable(flag_reg) && !hostDataOe)
        else $error("nack did not leave status intact");

    a_last_t_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == hibir_pkg::ST_DATA && sclFall && bitCnt_reg == 4'h8 && !busStop && !abortT)
        |=> drvBit_reg == ($past(byteIdx_reg) != $past(lastIdx)) && bitCnt_reg == 4'h9)
        else $error("transition bit value wrong");

endmodule // hibir_requester

// file: shared/hibir_consts.svh
`ifndef HIBIR_CONSTS_SVH
`define HIBIR_CONSTS_SVH

// interrupt configuration fields
`define HIBIR_GLOBAL_EN_BIT 4
`define HIBIR_TEMP_EN_MSB 3
`define HIBIR_CFG_RESET 8'h00
// error status bits that may raise an interrupt: [7:5] and [1:0]
`define HIBIR_ERR_MASK 8'hE3
`define HIBIR_TEMP_MASK 8'h0F

// pending-interrupt codes
`define HIBIR_PEND_SET 4'h1
`define HIBIR_PEND_CLR 4'h0

// request address: type code then hub select then read bit
`define HIBIR_LOCAL_TYPE 4'hA
`define HIBIR_MDB 8'h00
`define HIBIR_CRC_POLY 8'h07
`define HIBIR_CRC_INIT 8'h00

// bus-available time and its cycle count at the core clock
`define HIBIR_AVAL_NS 1000
`define HIBIR_CLK_MHZ 100
`define HIBIR_AVAL_CYC ((`HIBIR_AVAL_NS * `HIBIR_CLK_MHZ + 999) / 1000)

`endif

// file: shared/hibir_pkg.sv
package hibir_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_ADDR,
        ST_ACK,
        ST_DATA,
        ST_WAIT
    } hibir_state_t;

endpackage

// file: tb/hibir_host_model.sv
`timescale 1ns/10ps

module hibir_host_model (
    // host bus pins
    output logic hostClockLine,
    output logic hostDataIn,
    input logic hostDataOut,
    input logic hostDataOe,
    // captured unit, byte then ninth bit
    output logic [8:0] rxUnit,
    output logic rxValid
);
    localparam realtime HALF = 62.5;
    logic hostLow;

    // pulled-up wire: released means high, any low driver wins
    assign hostDataIn = (~hostDataOe | hostDataOut) & ~hostLow;

    initial begin
        hostClockLine = 1'b1;
        hostLow = 1'b0;
        rxUnit = 9'h000;
        rxValid = 1'b0;
    end

    // drive bits pull low; data moves 20 ns after the fall so no false start or stop is seen
    task automatic clockUnit(input logic [8:0] drive);
        for (int i = 8; i >= 0; i--) begin
            hostClockLine = 1'b0;
            #20 hostLow = drive[i];
            #(HALF - 20);
            hostClockLine = 1'b1;
            rxUnit[i] = hostDataIn;
            rxValid = (i == 0);
            #(HALF);
        end
        rxValid = 1'b0;
    endtask

    task automatic frame(input logic [7:0] rival, input logic ack, input int nPay, input int abortAt);
        if (hostDataIn === 1'b1)
            hostLow = 1'b1;
        #(HALF);
        clockUnit({rival, ack});
        for (int b = 0; ack && b < nPay; b++) begin
            clockUnit({8'h00, b == abortAt});
            if (b == abortAt)
                break;
        end
        hostClockLine = 1'b0;
        #20 hostLow = 1'b1;
        #(HALF);
        hostClockLine = 1'b1;
        #(HALF) hostLow = 1'b0;
        #(HALF);
    endtask
endmodule // hibir_host_model

// file: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    logic ref_clk, rst, i3cMode, pecEnable, cfgWrite, hostClockLine, hostDataIn;
    logic hostDataOut, hostDataOe, ibiStatusFlag, ibiBusy, rxValid;
    logic [2:0] hubSelectCode;
    logic [7:0] cfgData, tempEventStatus, errorEventStatus, interruptConfig;
    logic [3:0] pendingBits;
    logic [8:0] rxUnit;
    logic [8:0] expQ[$];
    int failures, comparisons, cycles, seedDummy;
    int errIdx[5] = '{0, 1, 5, 6, 7};

    hibir_requester dut (.ref_clk(ref_clk), .rst(rst), .i3cMode(i3cMode), .pecEnable(pecEnable),
        .hubSelectCode(hubSelectCode), .cfgWrite(cfgWrite), .cfgData(cfgData),
        .tempEventStatus(tempEventStatus), .errorEventStatus(errorEventStatus),
        .hostClockLine(hostClockLine), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .interruptConfig(interruptConfig), .ibiStatusFlag(ibiStatusFlag),
        .pendingBits(pendingBits), .ibiBusy(ibiBusy));

    hibir_host_model host (.hostClockLine(hostClockLine), .hostDataIn(hostDataIn),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .rxUnit(rxUnit), .rxValid(rxValid));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // whole run needs about 3k cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge rxValid) begin
        if (expQ.size() == 0) begin
            failures++;
            $display("BAD %0t seen %h expected none", $time, rxUnit);
        end else begin
            check(rxUnit, expQ.pop_front());
        end
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        return r;
    endfunction

    task automatic resetDut();
        @(negedge ref_clk);
        rst = 1'b1;
        tempEventStatus = 8'h00;
        errorEventStatus = 8'h00;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic cfg(input logic [7:0] v);
        @(negedge ref_clk);
        cfgWrite = 1'b1;
        cfgData = v;
        @(negedge ref_clk);
        cfgWrite = 1'b0;
        @(negedge ref_clk);
        check({1'b0, interruptConfig}, {1'b0, v});
    endtask

    task automatic raise(input logic isErr, input int idx);
        @(negedge ref_clk);
        if (isErr)
            errorEventStatus[idx] = 1'b1;
        else
            tempEventStatus[idx] = 1'b1;
    endtask

    task automatic status(input logic flag, input logic [3:0] pend);
        repeat (8) @(negedge ref_clk);
        check({3'h0, ibiBusy, ibiStatusFlag, pendingBits}, {4'h0, flag, pend});
    endtask

    // longer than the bus-available time, so a wrongly armed request would show
    task automatic noRequest();
        logic seen;
        seen = 1'b0;
        repeat (150) @(negedge ref_clk) seen |= hostDataOe;
        check({8'h00, seen}, 9'h000);
    endtask

    task automatic waitReq();
        int n;
        n = 0;
        while (hostDataOe !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check({8'h00, hostDataOe}, 9'h001);
    endtask

    task automatic expectFrame(input logic ack, input int nPay, input int abortAt);
        logic [7:0] pay[4];
        logic [7:0] adr;
        adr = {4'hA, hubSelectCode, 1'b1};
        pay = '{8'h00, tempEventStatus, errorEventStatus, 8'h00};
        pay[3] = crc8(crc8(crc8(crc8(8'h00, adr), pay[0]), pay[1]), pay[2]);
        expQ.push_back({adr, ~ack});
        for (int b = 0; ack && b < nPay && b <= abortAt; b++)
            expQ.push_back({pay[b], b < nPay - 1 && b != abortAt});
    endtask

    initial begin
        rst = 1'b1;
        {i3cMode, pecEnable, cfgWrite, cfgData} = 11'h000;
        {failures, comparisons, cycles} = '0;
        seedDummy = $urandom(43223);
        hubSelectCode = 3'($urandom_range(7, 1));
        resetDut();
        status(1'b0, 4'h0);
        i3cMode = 1'b1;
        raise(1'b1, 5);
        status(1'b1, 4'h1);
        noRequest();
        // legacy mode: status moves but the bus is never touched
        resetDut();
        i3cMode = 1'b0;
        cfg(8'h1F);
        raise(1'b1, 1);
        status(1'b1, 4'h1);
        noRequest();
        // idle-bus request, refused once, then accepted
        resetDut();
        i3cMode = 1'b1;
        errorEventStatus = 8'($urandom) & 8'h1C;
        tempEventStatus = 8'($urandom) & 8'hF0;
        cfg(8'h1F);
        raise(1'b1, errIdx[$urandom_range(4)]);
        waitReq();
        expectFrame(1'b0, 0, 9);
        host.frame(8'h00, 1'b0, 0, 9);
        status(1'b1, 4'h1);
        waitReq();
        expectFrame(1'b1, 3, 9);
        host.frame(8'h00, 1'b1, 3, 9);
        status(1'b0, 4'h0);
        // start-driven request with checksum, aborted at a transition bit then completed
        // raised soon after the stop so the quiet-bus timer cannot beat the host's start
        pecEnable = 1'b1;
        raise(1'b0, 2);
        status(1'b1, 4'h1);
        expectFrame(1'b1, 4, 1);
        host.frame(8'h00, 1'b1, 4, 1);
        status(1'b1, 4'h1);
        expectFrame(1'b1, 4, 9);
        host.frame(8'h00, 1'b1, 4, 9);
        status(1'b0, 4'h0);
        noRequest();
        // temperature enables without the global enable
        resetDut();
        cfg(8'h0E);
        raise(1'b0, 0);
        status(1'b0, 4'h0);
        raise(1'b0, 3);
        status(1'b1, 4'h1);
        noRequest();
        // a hub with select code zero outbids this one
        resetDut();
        pecEnable = 1'b0;
        cfg(8'h10);
        raise(1'b1, 0);
        waitReq();
        expQ.push_back(9'h143);
        host.frame(8'h0E, 1'b0, 0, 9);
        status(1'b1, 4'h1);
        if (expQ.size() != 0) begin
            failures++;
            $display("BAD %0t units missing, next expected %h", $time, expQ[0]);
        end
        conclude();
    end
endmodule // testbench
